/* File: inc/icmc_regs.vh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * two-wire bus mode control block.
 * assumes a 200 MHz system clock and byte addresses on a 32-bit bus.
 */
`ifndef ICMC_REGS_VH
`define ICMC_REGS_VH

// =====================================================================
// register byte offsets
`define ICMC_OFS_CTRL 8'h00
`define ICMC_OFS_SADDR 8'h04
`define ICMC_OFS_SADDR2 8'h08
`define ICMC_OFS_MODE 8'h0C
`define ICMC_OFS_DATA 8'h10
`define ICMC_OFS_STAT 8'h14

// =====================================================================
// control register fields
`define ICMC_CTRL_ENABLE 7
`define ICMC_CTRL_IRQEN 6
`define ICMC_CTRL_MST 5
`define ICMC_CTRL_TRS 4
`define ICMC_CTRL_RST 8'h00

// =====================================================================
// status register fields
`define ICMC_ST_BYTE 0
`define ICMC_ST_ARBLOST 1
`define ICMC_ST_START 2
`define ICMC_ST_STOP 3
`define ICMC_ST_BUSY 4
`define ICMC_ST_XFER 5
`define ICMC_EVT_W 4

// =====================================================================
// mode pairs and reset values
`define ICMC_MODE_SLV_RX 2'b00
`define ICMC_MODE_SLV_TX 2'b01
`define ICMC_MODE_MST_RX 2'b10
`define ICMC_MODE_MST_TX 2'b11
`define ICMC_REG8_RST 8'h00
`define ICMC_BITS_PER_FRAME 4'h9

// =====================================================================
// timing
`define ICMC_CLK_PERIOD_NS 5
`define ICMC_SCL_HALF_NS 2500
`define ICMC_SCL_HALF_CYC (`ICMC_SCL_HALF_NS / `ICMC_CLK_PERIOD_NS)

`endif

/* File: logic/icmc_top.v */
/*
 * two-wire bus mode control: enable, interrupt gate, master/slave and
 * transmit/receive selection with hardware updates, avalon-mm slave.
 * assumes bus pins are open-drain with external pull-ups and that the
 * bench resolves each wire from the output enables.
 */
// Local design decisions: register access over Avalon-MM and the register addresses.
`default_nettype none
`include "icmc_regs.vh"

// Operation
// - enable clear: stop, init, address regs open
// - enable set: transfers, pins, mode/data regs
// - cpu interrupt passes only while enabled
// - mode pair decode, both reset zero
// - lost arbitration clears master and transmit
// - first frame r/w bit sets direction in slave receive mode
// - transmit change mid-transfer deferred until end
module icmc_top #(
    parameter SCL_HALF_CYC = `ICMC_SCL_HALF_CYC
) (
    // clock and reset
    input wire MCLK_IN,
    input wire ARST_N_IN,
    // avalon-mm slave
    input wire [7:0] AVS_ADDRESS_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire [3:0] AVS_BYTEENABLE_IN,
    input wire [31:0] AVS_WRITEDATA_IN,
    output wire [31:0] AVS_READDATA_OUT,
    output wire AVS_WAITREQUEST_OUT,
    // two-wire bus pins
    input wire SCL_IN,
    output wire SCL_OUT,
    output wire SCL_OE_OUT,
    input wire SDA_IN,
    output wire SDA_OUT,
    output wire SDA_OE_OUT,
    // system
    output wire PIN_FUNC_OUT,
    output wire IRQ_OUT
);

// =====================================================================
// pin synchronisers
reg scl_s1_r, scl_s2_r, scl_d_r;
reg sda_s1_r, sda_s2_r, sda_d_r;
always @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
        scl_s1_r <= 1'b1;
        scl_s2_r <= 1'b1;
        scl_d_r <= 1'b1;
        sda_s1_r <= 1'b1;
        sda_s2_r <= 1'b1;
        sda_d_r <= 1'b1;
    end else begin
        scl_s1_r <= SCL_IN;
        scl_s2_r <= scl_s1_r;
        scl_d_r <= scl_s2_r;
        sda_s1_r <= SDA_IN;
        sda_s2_r <= sda_s1_r;
        sda_d_r <= sda_s2_r;
    end
end

wire scl_rise = scl_s2_r & ~scl_d_r;
wire scl_fall = ~scl_s2_r & scl_d_r;
wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

// =====================================================================
// registers and state
reg [7:0] ctrl_r;
reg [7:0] saddr_r, saddr2_r, mode_r, tx_r, rx_r, shift_r;
reg [`ICMC_EVT_W-1:0] evt_r;
reg [3:0] bitcnt_r;
reg busy_r, first_r, trs_pend_r, trs_val_r, go_r, scl_low_r, sda_drv_r;
reg [15:0] div_r;
reg wait_r, irq_r;
reg [31:0] rdata_r;

wire enable = ctrl_r[`ICMC_CTRL_ENABLE];
wire master_select = ctrl_r[`ICMC_CTRL_MST];
wire transmit_select = ctrl_r[`ICMC_CTRL_TRS];
wire xfer = bitcnt_r != 4'h0;
wire frame_end = scl_rise && (bitcnt_r == (`ICMC_BITS_PER_FRAME - 4'h1));
wire data_bit = bitcnt_r < 4'h8;
wire arb_lost = enable && master_select && scl_rise && data_bit
                && !sda_drv_r && !sda_s2_r;

// =====================================================================
// avalon decode
wire acc = (AVS_READ_IN | AVS_WRITE_IN) & ~wait_r;
wire wr = AVS_WRITE_IN & ~wait_r & AVS_BYTEENABLE_IN[0];
wire [7:0] wd = AVS_WRITEDATA_IN[7:0];
wire sel_ctrl = AVS_ADDRESS_IN == `ICMC_OFS_CTRL;
wire sel_sa = AVS_ADDRESS_IN == `ICMC_OFS_SADDR && !enable;
wire sel_sa2 = AVS_ADDRESS_IN == `ICMC_OFS_SADDR2 && !enable;
wire sel_mode = AVS_ADDRESS_IN == `ICMC_OFS_MODE && enable;
wire sel_data = AVS_ADDRESS_IN == `ICMC_OFS_DATA && enable;
wire sel_stat = AVS_ADDRESS_IN == `ICMC_OFS_STAT;

reg [7:0] rd_nxt;
always @* begin
    rd_nxt = `ICMC_REG8_RST;
    if (sel_ctrl) begin
        rd_nxt = ctrl_r;
    end else if (sel_sa) begin
        rd_nxt = saddr_r;
    end else if (sel_sa2) begin
        rd_nxt = saddr2_r;
    end else if (sel_mode) begin
        rd_nxt = mode_r;
    end else if (sel_data) begin
        rd_nxt = rx_r;
    end else if (sel_stat) begin
        rd_nxt = {2'b00, xfer, busy_r, evt_r};
    end
end

// one wait state, access completes at the edge wait is seen low
always @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
        wait_r <= 1'b1;
        rdata_r <= 32'h0000_0000;
    end else begin
        wait_r <= ~((AVS_READ_IN | AVS_WRITE_IN) & wait_r);
        if ((AVS_READ_IN | AVS_WRITE_IN) & wait_r) begin
            rdata_r <= {24'h00_0000, rd_nxt};
        end
    end
end

// =====================================================================
// control register with hardware updates
reg [7:0] ctrl_nxt;
reg trs_pend_nxt, trs_val_nxt;
always @* begin
    ctrl_nxt = ctrl_r;
    trs_pend_nxt = trs_pend_r;
    trs_val_nxt = trs_val_r;
    if (wr && sel_ctrl) begin
        ctrl_nxt[7:5] = wd[7:5];
        if (xfer && wd[`ICMC_CTRL_TRS] != transmit_select) begin
            trs_pend_nxt = 1'b1;
            trs_val_nxt = wd[`ICMC_CTRL_TRS];
        end else begin
            ctrl_nxt[`ICMC_CTRL_TRS] = wd[`ICMC_CTRL_TRS];
            trs_pend_nxt = 1'b0;
        end
    end
    if (frame_end && trs_pend_r) begin
        ctrl_nxt[`ICMC_CTRL_TRS] = trs_val_r;
        trs_pend_nxt = 1'b0;
    end
    if (enable && scl_rise && first_r && bitcnt_r == 4'h7
        && {master_select, transmit_select} == `ICMC_MODE_SLV_RX) begin
        ctrl_nxt[`ICMC_CTRL_TRS] = sda_s2_r;
    end
    if (arb_lost) begin
        ctrl_nxt[`ICMC_CTRL_MST] = 1'b0;
        ctrl_nxt[`ICMC_CTRL_TRS] = 1'b0;
        trs_pend_nxt = 1'b0;
    end
    ctrl_nxt[3:0] = 4'h0;
end

// =====================================================================
// event flags: write one to clear, a new event wins
wire [`ICMC_EVT_W-1:0] evt_set = {stop_det, start_det, arb_lost, frame_end};
wire [`ICMC_EVT_W-1:0] evt_clr =
    (wr && sel_stat) ? wd[`ICMC_EVT_W-1:0] : {`ICMC_EVT_W{1'b0}};

always @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
        ctrl_r <= `ICMC_CTRL_RST;
        trs_pend_r <= 1'b0;
        trs_val_r <= 1'b0;
        saddr_r <= `ICMC_REG8_RST;
        saddr2_r <= `ICMC_REG8_RST;
        mode_r <= `ICMC_REG8_RST;
        tx_r <= `ICMC_REG8_RST;
        evt_r <= {`ICMC_EVT_W{1'b0}};
        irq_r <= 1'b0;
    end else begin
        ctrl_r <= ctrl_nxt;
        trs_pend_r <= trs_pend_nxt & ctrl_nxt[`ICMC_CTRL_ENABLE];
        trs_val_r <= trs_val_nxt;
        if (wr && sel_sa) begin
            saddr_r <= wd;
        end
        if (wr && sel_sa2) begin
            saddr2_r <= wd;
        end
        if (wr && sel_mode) begin
            mode_r <= wd;
        end
        if (wr && sel_data) begin
            tx_r <= wd;
        end
        if (!enable) begin
            evt_r <= {`ICMC_EVT_W{1'b0}};
        end else begin
            evt_r <= (evt_r & ~evt_clr) | evt_set;
        end
        irq_r <= ctrl_r[`ICMC_CTRL_IRQEN] & (|evt_r);
    end
end

// =====================================================================
// frame tracking, shifting, master clock
always @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
        busy_r <= 1'b0;
        first_r <= 1'b0;
        bitcnt_r <= 4'h0;
        shift_r <= `ICMC_REG8_RST;
        rx_r <= `ICMC_REG8_RST;
        sda_drv_r <= 1'b0;
        go_r <= 1'b0;
        scl_low_r <= 1'b0;
        div_r <= 16'h0000;
    end else if (!enable) begin
        busy_r <= 1'b0;
        first_r <= 1'b0;
        bitcnt_r <= 4'h0;
        shift_r <= `ICMC_REG8_RST;
        sda_drv_r <= 1'b0;
        go_r <= 1'b0;
        scl_low_r <= 1'b0;
        div_r <= 16'h0000;
    end else begin
        if (start_det) begin
            busy_r <= 1'b1;
            first_r <= 1'b1;
            bitcnt_r <= 4'h0;
        end else if (stop_det) begin
            busy_r <= 1'b0;
            bitcnt_r <= 4'h0;
        end else if (frame_end) begin
            bitcnt_r <= 4'h0;
            first_r <= 1'b0;
            rx_r <= shift_r;
        end else if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 4'h1;
            if (data_bit) begin
                shift_r <= {shift_r[6:0], sda_s2_r};
            end
        end
        if (wr && sel_data) begin
            shift_r <= wd;
            go_r <= master_select;
        end else if (frame_end || arb_lost) begin
            go_r <= 1'b0;
        end
        if (arb_lost) begin
            sda_drv_r <= 1'b0;
        end else if (scl_fall || (wr && sel_data)) begin
            sda_drv_r <= transmit_select && !(wr && sel_data ? wd[7] : shift_r[7])
                         && (wr && sel_data || bitcnt_r < 4'h8);
        end
        if (go_r) begin
            if (div_r >= SCL_HALF_CYC[15:0] - 16'h0001) begin
                div_r <= 16'h0000;
                scl_low_r <= ~scl_low_r;
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end else begin
            div_r <= 16'h0000;
            scl_low_r <= 1'b0;
        end
    end
end

// =====================================================================
// outputs
assign AVS_READDATA_OUT = rdata_r;
assign AVS_WAITREQUEST_OUT = wait_r;
assign SCL_OUT = 1'b0;
assign SCL_OE_OUT = scl_low_r;
assign SDA_OUT = 1'b0;
assign SDA_OE_OUT = sda_drv_r;
assign PIN_FUNC_OUT = ctrl_r[`ICMC_CTRL_ENABLE];
assign IRQ_OUT = irq_r;

endmodule // icmc_top
`default_nettype wire

/* File: testbench/icmc_top_monitor.sv */
/* checker on the icmc_top ports.
   bound from the bench top file. */
`default_nettype none
module icmc_top_monitor (
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [7:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic SCL_OE_OUT,
    input wire logic SDA_OE_OUT,
    input wire logic PIN_FUNC_OUT,
    input wire logic IRQ_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    wire ack = !AVS_WAITREQUEST_OUT;
    wire wc = AVS_WRITE_IN && ack && AVS_ADDRESS_IN == 8'h00;
    wire wd7 = AVS_WRITEDATA_IN[7];
    property p_init;
        $rose(ARST_N_IN) |-> AVS_WAITREQUEST_OUT && !PIN_FUNC_OUT && !IRQ_OUT;
    endproperty
    a_init: assert property (p_init) else $error("reset state");
    property p_idle;
        !PIN_FUNC_OUT && !$past(PIN_FUNC_OUT) |-> !SCL_OE_OUT && !SDA_OE_OUT;
    endproperty
    a_idle: assert property (p_idle) else $error("pins driven");
    property p_mode;
        AVS_READ_IN && ack && AVS_ADDRESS_IN == 8'h0c && !PIN_FUNC_OUT
            |-> AVS_READDATA_OUT == 32'h0000_0000;
    endproperty
    a_mode: assert property (p_mode) else $error("mode read");
    property p_saddr;
        AVS_READ_IN && ack && AVS_ADDRESS_IN == 8'h04 && PIN_FUNC_OUT
            |-> AVS_READDATA_OUT == 32'h0000_0000;
    endproperty
    a_saddr: assert property (p_saddr) else $error("addr read");
    property p_func;
        wc |-> ##2 PIN_FUNC_OUT == $past(wd7, 2);
    endproperty
    a_func: assert property (p_func) else $error("pin func");
    property p_block;
        wc && !AVS_WRITEDATA_IN[6] |-> ##2 !IRQ_OUT;
    endproperty
    a_block: assert property (p_block) else $error("irq not off");
    property p_gate;
        $rose(IRQ_OUT) |-> PIN_FUNC_OUT;
    endproperty
    a_gate: assert property (p_gate) else $error("irq off");
    property p_wait;
        ack |=> AVS_WAITREQUEST_OUT;
    endproperty
    a_wait: assert property (p_wait) else $error("wait");
endmodule // icmc_top_monitor
`default_nettype wire

/* File: testbench/icmc_peer.sv */
/* peer on the two-wire bus: start, nine bits, stop.
   assumes pull-ups resolved by the bench. */
`default_nettype none
module icmc_peer (
    // open-drain pulls
    output logic scl_oe_out,
    output logic sda_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drv = 1'b0;
    logic hold_low = 1'b0;
    logic clk_low = 1'b0;
    assign scl_oe_out = clk_low;
    assign sda_oe_out = drv | hold_low;
    task automatic frame(input logic [7:0] b);
        drv = 1'b1;
        #62.5;
        for (int i = 0; i < 9; i++) begin
            clk_low = 1'b1;
            drv = (i < 8) ? !b[7-i] : 1'b0;
            #62.5;
            clk_low = 1'b0;
            #62.5;
        end
        clk_low = 1'b1;
        drv = 1'b1;
        #62.5;
        clk_low = 1'b0;
        #62.5;
        drv = 1'b0;
        #62.5;
    endtask
endmodule // icmc_peer
`default_nettype wire

/* File: testbench/icmc_top_bench.sv */
/* self-checking bench of icmc_top.
   assumes pull-ups on both wires. */
`default_nettype none
module icmc_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [7:0] q;
    wire [31:0] rdat;
    wire wreq, scl_oe, sda_oe, p_scl, p_sda, pin_func, irq;
    wire scl = !(scl_oe | p_scl);
    wire sda = !(sda_oe | p_sda);
    int fails = 0;
    int samples_checked = 0;
    always #2.5 clk = !clk;
    icmc_top #(.SCL_HALF_CYC(4)) icmc_top_inst (
        .MCLK_IN(clk), .ARST_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'hf),
        .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
        .AVS_WAITREQUEST_OUT(wreq), .SCL_IN(scl), .SCL_OUT(),
        .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
        .PIN_FUNC_OUT(pin_func), .IRQ_OUT(irq));
    icmc_peer icmc_peer_inst (.scl_oe_out(p_scl), .sda_oe_out(p_sda));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h00_0000, d};
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic test_done;
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, 8'h00, 8'h00);
        chk(q, 8'h00);
        acc(1, 8'h04, 8'h5a);
        acc(0, 8'h04, 8'h00);
        chk(q, 8'h5a);
        acc(0, 8'h0c, 8'h00);
        chk(q, 8'h00);
        chk({7'h00, pin_func}, 8'h00);
        acc(1, 8'h00, 8'h80);
        acc(1, 8'h0c, 8'h33);
        chk({7'h00, pin_func}, 8'h01);
        acc(0, 8'h0c, 8'h00);
        chk(q, 8'h33);
        acc(0, 8'h04, 8'h00);
        chk(q, 8'h00);
        for (int m = 0; m < 4; m++) begin
            acc(1, 8'h00, {2'b10, 2'(m), 4'h0});
            acc(0, 8'h00, 8'h00);
            chk(q, {2'b10, 2'(m), 4'h0});
        end
        acc(1, 8'h00, 8'h80);
        icmc_peer_inst.frame(8'ha3);
        repeat (10) @(posedge clk);
        acc(0, 8'h00, 8'h00);
        chk(q, 8'h90);
        acc(0, 8'h10, 8'h00);
        chk(q, 8'ha3);
        acc(0, 8'h14, 8'h00);
        chk(q, 8'h0d);
        chk({7'h00, irq}, 8'h00);
        acc(1, 8'h00, 8'hc0);
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        acc(1, 8'h14, 8'h0f);
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        fork
            icmc_peer_inst.frame(8'h50);
            begin
                repeat (80) @(posedge clk);
                acc(1, 8'h00, 8'h90);
                acc(0, 8'h00, 8'h00);
                chk(q, 8'h80);
            end
        join
        repeat (10) @(posedge clk);
        acc(0, 8'h00, 8'h00);
        chk(q, 8'h90);
        acc(1, 8'h00, 8'hb0);
        icmc_peer_inst.hold_low <= 1'b1;
        acc(1, 8'h10, 8'hff);
        repeat (100) @(posedge clk);
        icmc_peer_inst.hold_low <= 1'b0;
        acc(0, 8'h00, 8'h00);
        chk(q, 8'h80);
        acc(0, 8'h14, 8'h00);
        chk(q & 8'h02, 8'h02);
        acc(1, 8'h00, 8'h00);
        acc(0, 8'h14, 8'h00);
        chk(q, 8'h00);
        chk({7'h00, pin_func}, 8'h00);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        test_done;
    end
endmodule // icmc_top_bench
bind icmc_top icmc_top_monitor icmc_top_monitor_inst (
    .MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .SCL_OE_OUT(SCL_OE_OUT),
    .SDA_OE_OUT(SDA_OE_OUT), .PIN_FUNC_OUT(PIN_FUNC_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire
